// File: msppr_regs.sv
// Status, indirect pointer, port data, power, wake enable, pc high, pull-down and open-drain registers.
// Assumes the core presents one register access per instruction clock and pins already synchronous.
`timescale 1ns/1ps
module msppr_regs (
    input  wire logic                    clock,
    input  wire logic                    srst,
    input  wire logic [5:0]              reg_addr,
    input  wire logic                    reg_wr_en,
    input  wire logic [7:0]              reg_wr_data,
    output logic      [7:0]              reg_rd_data,
    input  wire logic                    clear_register_op,
    input  wire msppr_pkg::msppr_alu_op_t alu_op,
    input  wire logic [7:0]              alu_opnd_a,
    input  wire logic [7:0]              alu_opnd_b,
    input  wire logic                    alu_upd_zero,
    input  wire logic                    alu_upd_half,
    input  wire logic                    alu_upd_carry,
    output logic      [7:0]              alu_result,
    input  wire logic                    watchdog_clear_op,
    input  wire logic                    sleep_op,
    input  wire logic                    watchdog_overflow,
    input  wire logic                    wake_by_port_change,
    input  wire logic                    wake_by_other,
    input  wire logic                    dir_a_wr_en,
    input  wire logic                    dir_b_wr_en,
    input  wire logic                    port_change_flag_clr,
    input  wire logic [3:0]              port_a_in,
    output logic      [3:0]              port_a_out,
    output logic      [3:0]              port_a_oe,
    output logic      [3:0]              port_a_pull_down,
    input  wire logic [7:0]              port_b_in,
    output logic      [7:0]              port_b_out,
    output logic      [7:0]              port_b_oe,
    output logic      [2:0]              port_b_pull_down,
    output logic      [5:0]              indirect_pointer,
    output logic      [1:0]              pc_high_buffer,
    output logic                         watchdog_enable_bit,
    output logic                         low_voltage_detect_enable,
    output logic                         ext_irq_level,
    output logic                         port_change_flag
);
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [5:0] pointer_ff;
    logic [7:0] port_a_latch_ff;
    logic [7:0] port_b_latch_ff;
    logic [2:0] power_ff;
    logic [7:0] wake_en_ff;
    logic [1:0] pc_high_ff;
    logic [7:0] pulldown_ff;
    logic [7:0] opendrn_ff;
    logic [3:0] dir_a_ff;
    logic [7:0] dir_b_ff;
    logic [7:0] pin_b_prev_ff;
    logic       change_flag_ff;
    logic [7:0] change_hit;
    logic       wr_any;
    logic [7:0] wr_value;
    logic       alu_zero;
    logic       alu_half;
    logic       alu_carry;

    msppr_flag_alu u_alu (
        .clock      (clock),
        .srst       (srst),
        .op         (alu_op),
        .opnd_a     (alu_opnd_a),
        .opnd_b     (alu_opnd_b),
        .carry_in   (status_ff[msppr_pkg::BIT_CARRY]),
        .result     (alu_result),
        .zero       (alu_zero),
        .half_carry (alu_half),
        .carry      (alu_carry)
    );

    // A clear is a write of zero; on status it forces the zero flag to one and keeps carry and half-carry.
    assign wr_any   = reg_wr_en | clear_register_op;
    assign wr_value = clear_register_op ? 8'h00 : reg_wr_data;

    always_comb begin
        nxt_status = status_ff;
        if (wr_any && (reg_addr == msppr_pkg::OFF_STATUS)) begin
            nxt_status[7:5] = wr_value[7:5];
            nxt_status[msppr_pkg::BIT_ZERO]       = wr_value[msppr_pkg::BIT_ZERO];
            nxt_status[msppr_pkg::BIT_HALF_CARRY] = wr_value[msppr_pkg::BIT_HALF_CARRY];
            nxt_status[msppr_pkg::BIT_CARRY]      = wr_value[msppr_pkg::BIT_CARRY];
        end
        if (clear_register_op && (reg_addr == msppr_pkg::OFF_STATUS)) begin
            nxt_status[msppr_pkg::BIT_ZERO]       = 1'b1;
            nxt_status[msppr_pkg::BIT_HALF_CARRY] = status_ff[msppr_pkg::BIT_HALF_CARRY];
            nxt_status[msppr_pkg::BIT_CARRY]      = status_ff[msppr_pkg::BIT_CARRY];
        end else begin
            // When the instruction updates any flag, the written data reaches no flag, even one that it leaves alone.
            if (wr_any && (reg_addr == msppr_pkg::OFF_STATUS)
                    && (alu_upd_zero || alu_upd_half || alu_upd_carry)) begin
                nxt_status[msppr_pkg::BIT_ZERO]       = status_ff[msppr_pkg::BIT_ZERO];
                nxt_status[msppr_pkg::BIT_HALF_CARRY] = status_ff[msppr_pkg::BIT_HALF_CARRY];
                nxt_status[msppr_pkg::BIT_CARRY]      = status_ff[msppr_pkg::BIT_CARRY];
            end
            // Flag results outrank any data written to the same bits.
            if (alu_upd_zero) begin
                nxt_status[msppr_pkg::BIT_ZERO] = alu_zero;
            end
            if (alu_upd_half) begin
                nxt_status[msppr_pkg::BIT_HALF_CARRY] = alu_half;
            end
            if (alu_upd_carry) begin
                nxt_status[msppr_pkg::BIT_CARRY] = alu_carry;
            end
        end
        // Timeout and powerdown ignore writes; only their events move them.
        if (watchdog_overflow) begin
            nxt_status[msppr_pkg::BIT_TIMEOUT] = 1'b0;
        end
        if (watchdog_clear_op || sleep_op) begin
            nxt_status[msppr_pkg::BIT_TIMEOUT] = 1'b1;
        end
        if (sleep_op) begin
            nxt_status[msppr_pkg::BIT_POWERDOWN] = 1'b0;
        end
        if (watchdog_clear_op) begin
            nxt_status[msppr_pkg::BIT_POWERDOWN] = 1'b1;
        end
        if (wake_by_other) begin
            nxt_status[msppr_pkg::BIT_WAKE_CAUSE] = 1'b0;
        end
        if (wake_by_port_change) begin
            nxt_status[msppr_pkg::BIT_WAKE_CAUSE] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_ff <= msppr_pkg::RST_STATUS;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pointer_ff  <= msppr_pkg::RST_POINTER;
            power_ff    <= msppr_pkg::RST_POWER;
            wake_en_ff  <= msppr_pkg::RST_WAKE_EN;
            pc_high_ff  <= msppr_pkg::RST_PC_HIGH;
            pulldown_ff <= msppr_pkg::RST_PULLDOWN;
            opendrn_ff  <= msppr_pkg::RST_OPENDRN;
        end else if (wr_any) begin
            unique case (reg_addr)
                msppr_pkg::OFF_POINTER: begin
                    pointer_ff <= wr_value[5:0];
                end
                msppr_pkg::OFF_POWER: begin
                    power_ff <= wr_value[7:5];
                end
                msppr_pkg::OFF_WAKE_EN: begin
                    wake_en_ff <= wr_value;
                end
                msppr_pkg::OFF_PC_HIGH: begin
                    pc_high_ff <= wr_value[1:0];
                end
                msppr_pkg::OFF_PULLDOWN: begin
                    pulldown_ff <= wr_value;
                end
                msppr_pkg::OFF_OPENDRN: begin
                    opendrn_ff <= wr_value;
                end
                default: begin
                end
            endcase
        end
    end

    // Port writes land in the latches only; the pins are read back directly.
    always_ff @(posedge clock) begin
        if (srst) begin
            port_a_latch_ff <= msppr_pkg::RST_PORT;
            port_b_latch_ff <= msppr_pkg::RST_PORT;
        end else if (wr_any && (reg_addr == msppr_pkg::OFF_PORT_A)) begin
            port_a_latch_ff <= wr_value;
        end else if (wr_any && (reg_addr == msppr_pkg::OFF_PORT_B)) begin
            port_b_latch_ff <= wr_value;
        end
    end

    // Direction words come from the accumulator through the direction instruction.
    always_ff @(posedge clock) begin
        if (srst) begin
            dir_a_ff <= msppr_pkg::RST_DIR[3:0];
            dir_b_ff <= msppr_pkg::RST_DIR;
        end else begin
            if (dir_a_wr_en) begin
                dir_a_ff <= reg_wr_data[3:0];
            end
            if (dir_b_wr_en) begin
                dir_b_ff <= reg_wr_data;
            end
        end
    end

    // Pin 0 leaves the change path while it serves as the interrupt input.
    always_comb begin
        change_hit = (port_b_in ^ pin_b_prev_ff) & wake_en_ff;
        if (power_ff[msppr_pkg::BIT_IRQ_SEL - 5]) begin
            change_hit[0] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pin_b_prev_ff <= msppr_pkg::RST_PORT;
        end else begin
            pin_b_prev_ff <= port_b_in;
        end
    end

    // A change in the clearing cycle keeps the flag set.
    always_ff @(posedge clock) begin
        if (srst) begin
            change_flag_ff <= 1'b0;
        end else if (|change_hit) begin
            change_flag_ff <= 1'b1;
        end else if (port_change_flag_clr) begin
            change_flag_ff <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_port_b
            if (gi == msppr_pkg::PB_INPUT_ONLY) begin : g_input_only
                assign port_b_oe[gi]  = 1'b0;
                assign port_b_out[gi] = 1'b0;
            end else begin : g_drive
                // Open-drain pins only pull low, so a high latch floats the pin.
                assign port_b_oe[gi]  = ~dir_b_ff[gi] & ~(opendrn_ff[gi] & port_b_latch_ff[gi]);
                assign port_b_out[gi] = port_b_latch_ff[gi] & ~opendrn_ff[gi];
            end
        end
    endgenerate

    assign port_a_oe        = ~dir_a_ff;
    assign port_a_out       = port_a_latch_ff[3:0];
    assign port_a_pull_down = ~pulldown_ff[3:0] & dir_a_ff;
    assign port_b_pull_down = ~pulldown_ff[6:4] & dir_b_ff[2:0];

    assign indirect_pointer          = pointer_ff;
    assign pc_high_buffer            = pc_high_ff;
    assign watchdog_enable_bit       = power_ff[msppr_pkg::BIT_WDT_EN - 5];
    assign low_voltage_detect_enable = power_ff[msppr_pkg::BIT_LVD_EN - 5];
    assign ext_irq_level             = power_ff[msppr_pkg::BIT_IRQ_SEL - 5] & port_b_in[0];
    assign port_change_flag          = change_flag_ff;

    // Reads are combinational so the value is ready within the addressing cycle.
    always_comb begin
        unique case (reg_addr)
            msppr_pkg::OFF_STATUS:   reg_rd_data = status_ff;
            msppr_pkg::OFF_POINTER:  reg_rd_data = {msppr_pkg::POINTER_FILL, pointer_ff};
            msppr_pkg::OFF_PORT_A:   reg_rd_data = {port_a_latch_ff[7:4], port_a_in};
            msppr_pkg::OFF_PORT_B:   reg_rd_data = port_b_in;
            msppr_pkg::OFF_POWER:    reg_rd_data = {power_ff, msppr_pkg::POWER_FILL};
            msppr_pkg::OFF_WAKE_EN:  reg_rd_data = wake_en_ff;
            msppr_pkg::OFF_PC_HIGH:  reg_rd_data = {msppr_pkg::PC_HIGH_FILL, pc_high_ff};
            msppr_pkg::OFF_PULLDOWN: reg_rd_data = pulldown_ff;
            msppr_pkg::OFF_OPENDRN:  reg_rd_data = opendrn_ff;
            default:                 reg_rd_data = msppr_pkg::READ_NONE;
        endcase
    end

    default clocking regs_cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_flag_override: assert property (
            (reg_wr_en && !clear_register_op && (reg_addr == msppr_pkg::OFF_STATUS) && alu_upd_zero)
            |=> (status_ff[2] == $past(alu_zero)))
        else $error("written zero bit was not overridden by flag result");
    chk_flags_locked: assert property (
            (reg_wr_en && !clear_register_op && (reg_addr == msppr_pkg::OFF_STATUS)
            && alu_upd_carry && !alu_upd_zero && !alu_upd_half)
            |=> (status_ff[2:1] == $past(status_ff[2:1])))
        else $error("written data reached a flag that the instruction does not update");
    chk_timeout_locked: assert property ((!watchdog_clear_op && !sleep_op && !watchdog_overflow)
            |=> $stable(status_ff[4:3]))
        else $error("timeout or powerdown changed without an event");
    chk_clear_status: assert property ((clear_register_op && (reg_addr == msppr_pkg::OFF_STATUS)
            && !wake_by_port_change && !wake_by_other)
            |=> (status_ff[7:5] == 3'h0) && status_ff[2] && (status_ff[1:0] == $past(status_ff[1:0])))
        else $error("clear of status gave a wrong pattern");
    chk_wake_cause: assert property (wake_by_port_change |=> status_ff[7])
        else $error("wake cause not set after port change wake");
    chk_sleep_flags: assert property ((sleep_op && !watchdog_clear_op) |=> status_ff[4] && !status_ff[3])
        else $error("sleep did not set timeout and clear powerdown");
    chk_pointer_read: assert property ((reg_addr == msppr_pkg::OFF_POINTER) |-> (reg_rd_data[7:6] == 2'h3))
        else $error("pointer upper bits not read as ones");
    chk_port_b_read: assert property ((reg_addr == msppr_pkg::OFF_PORT_B) |-> (reg_rd_data == port_b_in))
        else $error("port b read is not the pin level");
    chk_pin3_input: assert property (!port_b_oe[3])
        else $error("input only pin is driven");
    chk_irq_mask: assert property (!power_ff[1] |-> !ext_irq_level)
        else $error("interrupt path open while pin is plain io");
    chk_change_sticky: assert property ((change_flag_ff && !port_change_flag_clr) |=> change_flag_ff)
        else $error("port change flag dropped without a clear");
    chk_direction_float: assert property (dir_a_ff[0] |-> !port_a_oe[0])
        else $error("input direction still drives the pin");

    cov_port_wake: cover property (wake_by_port_change ##1 status_ff[7]);
    cov_change_clear: cover property (change_flag_ff && port_change_flag_clr && (|change_hit));
    cov_sub_flags: cover property (alu_upd_carry && (alu_op == msppr_pkg::MSPPR_OP_SUB) && !alu_carry);
    cov_overflow: cover property (watchdog_overflow ##1 !status_ff[4]);
endmodule

// File: msppr_pkg.sv
// Constants for the status, port and power register group.
// Shared by the register group and its flag computation unit.
package msppr_pkg;
    localparam logic [5:0] OFF_STATUS   = 6'h03;
    localparam logic [5:0] OFF_POINTER  = 6'h04;
    localparam logic [5:0] OFF_PORT_A   = 6'h05;
    localparam logic [5:0] OFF_PORT_B   = 6'h06;
    localparam logic [5:0] OFF_POWER    = 6'h08;
    localparam logic [5:0] OFF_WAKE_EN  = 6'h09;
    localparam logic [5:0] OFF_PC_HIGH  = 6'h0a;
    localparam logic [5:0] OFF_PULLDOWN = 6'h0b;
    localparam logic [5:0] OFF_OPENDRN  = 6'h0c;

    localparam int BIT_WAKE_CAUSE = 7;
    localparam int BIT_TIMEOUT    = 4;
    localparam int BIT_POWERDOWN  = 3;
    localparam int BIT_ZERO       = 2;
    localparam int BIT_HALF_CARRY = 1;
    localparam int BIT_CARRY      = 0;
    localparam int BIT_WDT_EN     = 7;
    localparam int BIT_IRQ_SEL    = 6;
    localparam int BIT_LVD_EN     = 5;
    localparam int PB_INPUT_ONLY  = 3;

    localparam logic [7:0] RST_STATUS   = 8'h18;
    localparam logic [5:0] RST_POINTER  = 6'h00;
    localparam logic [7:0] RST_PORT     = 8'h00;
    localparam logic [2:0] RST_POWER    = 3'h0;
    localparam logic [7:0] RST_WAKE_EN  = 8'h00;
    localparam logic [1:0] RST_PC_HIGH  = 2'h0;
    localparam logic [7:0] RST_PULLDOWN = 8'hff;
    localparam logic [7:0] RST_OPENDRN  = 8'h00;
    localparam logic [7:0] RST_DIR      = 8'hff;

    localparam logic [1:0] POINTER_FILL = 2'h3;
    localparam logic [4:0] POWER_FILL   = 5'h1f;
    localparam logic [5:0] PC_HIGH_FILL = 6'h00;
    localparam logic [7:0] READ_NONE    = 8'h00;

    typedef enum logic [2:0] {
        MSPPR_OP_PASS,
        MSPPR_OP_ADD,
        MSPPR_OP_SUB,
        MSPPR_OP_ROR,
        MSPPR_OP_ROL
    } msppr_alu_op_t;
endpackage

// File: msppr_flag_alu.sv
// Arithmetic unit that produces the result and the zero, half-carry and carry flags.
// Purely combinational; the register group samples its flags on the instruction clock.
`timescale 1ns/1ps
module msppr_flag_alu (
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire msppr_pkg::msppr_alu_op_t op,
    input  wire logic [7:0]             opnd_a,
    input  wire logic [7:0]             opnd_b,
    input  wire logic                   carry_in,
    output logic      [7:0]             result,
    output logic                        zero,
    output logic                        half_carry,
    output logic                        carry
);
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] addend;
    logic       sub_in;

    // Subtraction reuses the adder with the inverted operand and a carry in of one.
    always_comb begin
        sub_in = (op == msppr_pkg::MSPPR_OP_SUB);
        addend = sub_in ? ~opnd_b : opnd_b;
        sum9   = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, sub_in};
        sum5   = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_in};
    end

    always_comb begin
        result     = opnd_a;
        half_carry = 1'b0;
        carry      = carry_in;
        unique case (op)
            msppr_pkg::MSPPR_OP_PASS: begin
                result = opnd_a;
            end
            msppr_pkg::MSPPR_OP_ADD, msppr_pkg::MSPPR_OP_SUB: begin
                result     = sum9[7:0];
                half_carry = sum5[4];
                carry      = sum9[8];
            end
            msppr_pkg::MSPPR_OP_ROR: begin
                result = {carry_in, opnd_a[7:1]};
                carry  = opnd_a[0];
            end
            msppr_pkg::MSPPR_OP_ROL: begin
                result = {opnd_a[6:0], carry_in};
                carry  = opnd_a[7];
            end
            default: begin
                result = opnd_a;
            end
        endcase
        zero = (result == 8'h00);
    end

    default clocking alu_cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_sub_no_borrow: assert property ((op == msppr_pkg::MSPPR_OP_SUB) |-> (carry == (opnd_a >= opnd_b)))
        else $error("carry after subtraction does not mark absence of borrow");
    chk_ror_carry_out: assert property ((op == msppr_pkg::MSPPR_OP_ROR) |-> (carry == opnd_a[0]))
        else $error("rotate right carry is not the low bit");
endmodule

// File: msppr_pin_model.sv
// Pin-side model of port B: resolves each pin from the driver, an outside source or the pull-down.
// Assumes the bench chooses per pin whether an outside source drives it.
`timescale 1ns/1ps
module msppr_pin_model (
    input  wire logic       clock,
    input  wire logic [7:0] port_b_out,
    input  wire logic [7:0] port_b_oe,
    input  wire logic [2:0] port_b_pull_down,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] port_b_in
);
    logic [7:0] prev_ff;

    always_ff @(posedge clock) begin
        prev_ff <= port_b_in;
    end

    // A released pin with no pull shows the inverse of its last level, so a stale value never passes.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (port_b_oe[i]) begin
                port_b_in[i] = port_b_out[i];
            end else if (ext_en[i]) begin
                port_b_in[i] = ext_val[i];
            end else if (i < 3 && port_b_pull_down[i % 3]) begin
                port_b_in[i] = 1'b0;
            end else begin
                port_b_in[i] = ~prev_ff[i];
            end
        end
    end
endmodule

// File: mcu_status_port_power_regs_bench.sv
// Self-checking bench for the status, port and power register group.
// Assumes pins of port B come from the pin model; port A pins are resolved here.
`timescale 1ns/1ps
module mcu_status_port_power_regs_bench;
    logic clock = 1'b0, srst = 1'b1, reg_wr_en = 1'b0, clear_register_op = 1'b0;
    logic alu_upd_zero = 1'b0, alu_upd_half = 1'b0, alu_upd_carry = 1'b0, watchdog_clear_op = 1'b0;
    logic sleep_op = 1'b0, watchdog_overflow = 1'b0, wake_by_port_change = 1'b0, wake_by_other = 1'b0;
    logic dir_a_wr_en = 1'b0, dir_b_wr_en = 1'b0, port_change_flag_clr = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wr_data = 8'h00, alu_opnd_a = 8'h00, alu_opnd_b = 8'h00, ext_val = 8'h3c, reg_rd_data;
    logic [7:0] alu_result, port_b_in, port_b_out, port_b_oe, ext_en = 8'hff;
    logic [3:0] a_ext = 4'h9, port_a_in, port_a_out, port_a_oe, port_a_pull_down;
    logic [2:0] port_b_pull_down;
    logic [5:0] indirect_pointer;
    logic [1:0] pc_high_buffer;
    logic       watchdog_enable_bit, low_voltage_detect_enable, ext_irq_level, port_change_flag;
    msppr_pkg::msppr_alu_op_t alu_op = msppr_pkg::MSPPR_OP_PASS;
    int n_errors = 0, checked = 0, cycles = 0;
    logic [24:0] tbl [7] = '{{3'd1, 8'h0f, 8'h01, 6'o27}, {3'd1, 8'hff, 8'h01, 6'o77}, {3'd2, 8'h05, 8'h06, 6'o07},
        {3'd2, 8'h10, 8'h01, 6'o17}, {3'd2, 8'h33, 8'h33, 6'o77}, {3'd3, 8'h01, 8'h00, 6'o11}, {3'd4, 8'h7f, 8'h00, 6'o01}};

    assign port_a_in = (port_a_out & port_a_oe) | (a_ext & ~port_a_oe);
    always #10 clock = ~clock;
    msppr_regs u_dut (.*);
    msppr_pin_model u_pins (.clock, .port_b_out, .port_b_oe, .port_b_pull_down, .ext_en, .ext_val, .port_b_in);

    task automatic summarize;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock); reg_addr = a; reg_wr_data = d; reg_wr_en = 1'b1;
        @(negedge clock); reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(negedge clock); reg_addr = a;
        #1 cmp(reg_rd_data & m, e);
    endtask
    task automatic ev(ref logic s);
        @(negedge clock); s = 1'b1;
        @(negedge clock); s = 1'b0;
    endtask
    task automatic dirs(input logic [7:0] d);
        @(negedge clock); reg_wr_data = d; dir_a_wr_en = 1'b1; dir_b_wr_en = 1'b1;
        @(negedge clock); dir_a_wr_en = 1'b0; dir_b_wr_en = 1'b0;
    endtask

    task automatic t_regs;
        rd(msppr_pkg::OFF_STATUS, 8'h18);
        rd(msppr_pkg::OFF_POWER, 8'h1f);
        rd(6'h07, 8'h00);
        wr(msppr_pkg::OFF_POINTER, 8'h2a); rd(msppr_pkg::OFF_POINTER, 8'hea);
        cmp({2'h0, indirect_pointer}, 8'h2a);
        wr(msppr_pkg::OFF_POWER, 8'ha0); rd(msppr_pkg::OFF_POWER, 8'hbf);
        cmp({6'h0, watchdog_enable_bit, low_voltage_detect_enable}, 8'h03);
        wr(msppr_pkg::OFF_PC_HIGH, 8'hfe); rd(msppr_pkg::OFF_PC_HIGH, 8'h02);
        cmp({6'h0, pc_high_buffer}, 8'h02);
        wr(msppr_pkg::OFF_STATUS, 8'h67); rd(msppr_pkg::OFF_STATUS, 8'h7f);
        @(negedge clock); clear_register_op = 1'b1;
        @(negedge clock); clear_register_op = 1'b0;
        rd(msppr_pkg::OFF_STATUS, 8'h1f);
        $display("test regs done");
    endtask

    // Each step writes the inverse flags; updated flags must show the result, the others keep their value.
    task automatic t_alu;
        logic [7:0] e;
        logic [2:0] f = 3'h7;
        foreach (tbl[i]) begin
            @(negedge clock);
            alu_op = msppr_pkg::msppr_alu_op_t'(tbl[i][24:22]); alu_opnd_a = tbl[i][21:14]; alu_opnd_b = tbl[i][13:6];
            {alu_upd_zero, alu_upd_half, alu_upd_carry} = tbl[i][2:0];
            reg_addr = msppr_pkg::OFF_STATUS; reg_wr_data = {5'h0c, ~tbl[i][5:3]}; reg_wr_en = 1'b1;
            e = (tbl[i][24:22] == 3'd1) ? alu_opnd_a + alu_opnd_b : alu_opnd_a - alu_opnd_b;
            #1 if (tbl[i][24:22] < 3'd3) cmp(alu_result, e);
            @(negedge clock); reg_wr_en = 1'b0; {alu_upd_zero, alu_upd_half, alu_upd_carry} = 3'h0;
            f = (tbl[i][5:3] & tbl[i][2:0]) | (f & ~tbl[i][2:0]);
            #1 cmp(reg_rd_data, {5'h0f, f});
        end
        $display("test alu done");
    endtask

    task automatic t_events;
        ev(watchdog_overflow); rd(msppr_pkg::OFF_STATUS, 8'h08, 8'h98);
        ev(sleep_op); rd(msppr_pkg::OFF_STATUS, 8'h10, 8'h98);
        ev(watchdog_clear_op); rd(msppr_pkg::OFF_STATUS, 8'h18, 8'h98);
        @(negedge clock); watchdog_overflow = 1'b1; wake_by_port_change = 1'b1;
        @(negedge clock); watchdog_overflow = 1'b0; wake_by_port_change = 1'b0;
        rd(msppr_pkg::OFF_STATUS, 8'h88, 8'h98);
        ev(wake_by_other); rd(msppr_pkg::OFF_STATUS, 8'h08, 8'h98);
        $display("test events done");
    endtask

    task automatic t_ports;
        dirs(8'h00);
        wr(msppr_pkg::OFF_PORT_B, 8'ha5); cmp(port_b_oe, 8'hf7);
        rd(msppr_pkg::OFF_PORT_B, 8'had);
        wr(msppr_pkg::OFF_OPENDRN, 8'hff); cmp(port_b_oe, 8'h52);
        cmp(port_b_out, 8'h00);
        rd(msppr_pkg::OFF_PORT_B, 8'h2c);
        wr(msppr_pkg::OFF_PORT_A, 8'ha5); cmp({port_a_oe, port_a_out}, 8'hf5);
        rd(msppr_pkg::OFF_PORT_A, 8'ha5);
        dirs(8'hff); rd(msppr_pkg::OFF_PORT_A, 8'ha9);
        wr(msppr_pkg::OFF_PULLDOWN, 8'h8a); cmp({port_b_pull_down, 1'b0, port_a_pull_down}, 8'he5);
        rd(msppr_pkg::OFF_PULLDOWN, 8'h8a);
        ext_en = 8'h00;
        rd(msppr_pkg::OFF_PORT_B, 8'h00, 8'h07);
        ext_en = 8'hff;
        wr(msppr_pkg::OFF_WAKE_EN, 8'h01); rd(msppr_pkg::OFF_WAKE_EN, 8'h01);
        ext_val = 8'h3e;
        @(negedge clock); #1 cmp({7'h0, port_change_flag}, 8'h00);
        ext_val = 8'h3f;
        repeat (2) @(negedge clock);
        #1 cmp({7'h0, port_change_flag}, 8'h01);
        ev(port_change_flag_clr); #1 cmp({7'h0, port_change_flag}, 8'h00);
        wr(msppr_pkg::OFF_POWER, 8'h40); cmp({7'h0, ext_irq_level}, 8'h01);
        ext_val = 8'h3e;
        repeat (2) @(negedge clock);
        #1 cmp({6'h0, ext_irq_level, port_change_flag}, 8'h00);
        rd(msppr_pkg::OFF_PORT_B, 8'h3e);
        $display("test ports done");
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(negedge clock);
        srst = 1'b0;
        t_regs();
        t_alu();
        t_events();
        t_ports();
        summarize();
    end
endmodule
